// >>> design/relay_pkg.sv
// Shared constants and carrier types for the output-mode and relay block
package relay_pkg;

    // ************************************************************
    // Nonvolatile and RAM cell addresses
    // ************************************************************
    localparam logic [7:0]  PWM_CTRL_ADDR   = 8'h02;
    localparam logic [7:0]  DIE_TEMP_ADDR   = 8'h06;
    localparam logic [7:0]  OBJ1_ADDR       = 8'h07;
    localparam logic [7:0]  OBJ2_ADDR       = 8'h08;
    localparam logic [7:0]  HYST_ADDR       = 8'h20;
    localparam logic [7:0]  THRESH_ADDR     = 8'h21;
    localparam logic [7:0]  CFG_ADDR        = 8'h25;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PWM_EN_BIT     = 1;
    localparam int DRIVE_TYPE_BIT = 2;
    localparam int RELAY_SEL_BIT  = 3;
    localparam int DUAL_IR_BIT    = 6;
    localparam int FIR_LSB        = 8;
    localparam int IIR_LSB        = 0;

    // ************************************************************
    // Reset values and result limits
    // ************************************************************
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    localparam logic [15:0] THRESH_RESET    = 16'h6ca7;
    localparam logic [15:0] HYST_RESET      = 16'h0064;
    localparam logic [15:0] DIE_TEMP_LOW    = 16'h2de4;
    localparam logic [15:0] DIE_TEMP_HIGH   = 16'h4dc4;
    localparam logic [9:0]  PWM_FULL        = 10'h3ff;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ     = 100;
    localparam int REQ_TIME_US = 1024;
    localparam int REQ_CYCLES  = REQ_TIME_US * CLK_MHZ;
    localparam int INIT_CYCLES = 16;
    localparam int STAGE_CYCLES = 4;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_INIT   = 2'b00,
        MODE_PWM    = 2'b01,
        MODE_RELAY  = 2'b10,
        MODE_SERIAL = 2'b11
    } out_mode_e;

    typedef enum logic [2:0] {
        ST_LOAD  = 3'b000,
        ST_AMB   = 3'b001,
        ST_OBJ1  = 3'b010,
        ST_OBJ2  = 3'b011,
        ST_PWM   = 3'b100
    } loop_state_e;

    typedef struct packed {
        logic [15:0] die_temp;
        logic [15:0] obj_first;
        logic [15:0] obj_second;
    } temps_s;

    typedef struct packed {
        logic        pin_out;
        logic        pin_oe_b;
    } pin_drive_s;

endpackage : relay_pkg

// >>> design/request_detect.sv
// Serial clock synchroniser and request-condition detector
`timescale 1ns/1ps
`default_nettype none
module request_detect #(
    parameter int REQ_CYCLES = relay_pkg::REQ_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Serial clock pin
    input  wire logic scl_in,
    // Detection result
    output logic      scl_level,
    output logic      request_seen
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic [31:0] cnt;
        logic        seen;
    } st_s;

    st_s st_q;
    st_s st_d;

    // Count low time; data line deliberately not an input at all
    always_comb begin
        st_d      = st_q;
        st_d.s1   = scl_in;
        st_d.s2   = st_q.s1;
        st_d.seen = 1'b0;
        if (st_q.s2) begin
            st_d.cnt = 32'h0;
        end else if (st_q.cnt < 32'(REQ_CYCLES)) begin
            st_d.cnt = st_q.cnt + 32'h1;
        end else if (st_q.cnt == 32'(REQ_CYCLES)) begin
            st_d.seen = 1'b1;
            st_d.cnt  = st_q.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q <= '{s1: 1'b1, s2: 1'b1, cnt: 32'h0, seen: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign scl_level    = st_q.s2;
    assign request_seen = st_q.seen;

    property p_req_after_low;
        @(posedge ref_clk) disable iff (!rst_b)
        request_seen |-> !$past(scl_level);
    endproperty
    a_req_after_low: assert property (p_req_after_low)
        else $error("request without low clock");
endmodule : request_detect
`default_nettype wire

// >>> design/relay_compare.sv
// Hysteresis comparator on the first object temperature
`timescale 1ns/1ps
`default_nettype none
module relay_compare (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Operands
    input  wire logic        update,
    input  wire logic [15:0] obj_temp,
    input  wire logic [15:0] threshold,
    input  wire logic [15:0] hysteresis,
    // Result
    output logic             relay_level
);
    typedef struct packed {
        logic lvl;
    } st_s;

    st_s         st_q;
    st_s         st_d;
    logic [16:0] upper;
    logic [16:0] lower;
    logic [16:0] obj_x;

    // Kelvin x100 threshold against 0.02 K units: compare on obj*2
    always_comb begin
        obj_x = {obj_temp, 1'b0};
        upper = {1'b0, threshold} + {1'b0, hysteresis};
        lower = (threshold > hysteresis) ? {1'b0, threshold - hysteresis} : 17'h0;
        st_d  = st_q;
        if (update) begin
            if (obj_x >= upper) begin
                st_d.lvl = 1'b1;
            end else if (obj_x <= lower) begin
                st_d.lvl = 1'b0;
            end
            // Between the points the level is kept
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q <= '{lvl: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign relay_level = st_q.lvl;

    property p_hold_between;
        @(posedge ref_clk) disable iff (!rst_b)
        (update && obj_x < upper && obj_x > lower) |=> $stable(relay_level);
    endproperty
    a_hold_between: assert property (p_hold_between)
        else $error("relay level moved inside hysteresis band");
endmodule : relay_compare
`default_nettype wire

// >>> design/out_mode_relay.sv
// Output-mode selection, result loop and thermal relay top level
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - With PWM on, request condition disables PWM and frees pin for data.
// - After request, PWM returns only after power cycle or sleep exit.
// - Request is serial clock low longer than the request time.
// - Serial data level is ignored while detecting the request.
// - PWM disabled in configuration means serial data right after reset.
// - Die temperature sits in cell 006h, limited to 2DE4h..4DC4h.
// - Object and die results are kelvin at 0.02 K per bit.
// - After reset, calibration loads and sensor count is chosen.
// - Measurement, compensation and linearization loop runs continuously.
// - Second object stage skipped with one IR sensor.
// - Each loop rescales result to 10 bits and loads PWM word.
// - One shared FIR length and one shared IIR length.
// - Relay compares first object temperature, drives a logic level.
// - Relay only when relay select set and PWM enabled.
// - Pin push-pull or open-drain low side per drive-type bit.
// - Threshold from cell 021h, hysteresis from cell 020h.
// - High at threshold plus hysteresis or more, low at minus or less.
// - Relay mode keeps measuring; serial entered by same request.
// - Relay returns only after a reset event.
// - Threshold is kelvin x100, hysteresis degrees x100.
// - On sleep wake-up PWM selected if configuration enables it.
module out_mode_relay #(
    parameter int REQ_CYCLES  = relay_pkg::REQ_CYCLES,
    parameter int INIT_CYCLES = relay_pkg::INIT_CYCLES
) (
    // Clock and reset (power-on or sleep exit)
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Serial clock pin
    input  wire logic        scl_in,
    // Shared data pin
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_b,
    // Serial-side data path from the protocol engine
    input  wire logic        ser_drive_low,
    // Nonvolatile cell access port
    input  wire logic        nv_wr,
    input  wire logic [7:0]  nv_addr,
    input  wire logic [15:0] nv_wdata,
    input  wire logic        ram_rd,
    input  wire logic [7:0]  ram_addr,
    output logic [15:0]      ram_rdata,
    // Raw measurement inputs from the analog front end
    input  wire logic [15:0] raw_die,
    input  wire logic [15:0] raw_obj1,
    input  wire logic [15:0] raw_obj2,
    // Status and PWM word
    output logic [1:0]       out_mode,
    output logic [9:0]       pwm_word,
    output logic             pwm_load,
    output logic             sda_seen
);
    typedef struct packed {
        relay_pkg::out_mode_e   mode;
        relay_pkg::loop_state_e lp;
        logic [15:0]            ctrl;
        logic [15:0]            cfg;
        logic [15:0]            thresh;
        logic [15:0]            hyst;
        relay_pkg::temps_s      t;
        logic [15:0]            iir_acc;
        logic [7:0]             tick;
        logic [9:0]             pwm;
        logic                   load;
        logic [15:0]            rdata;
        relay_pkg::pin_drive_s  pin;
        logic [1:0]             sda_s;
    } st_s;

    st_s         st_q;
    st_s         st_d;
    logic        scl_level;
    logic        request_seen;
    logic        relay_level;
    logic        relay_upd;
    logic        pwm_en;
    logic        relay_sel;
    logic        dual_ir;
    logic [3:0]  fir_len;
    logic [3:0]  iir_len;
    logic [15:0] die_clamped;
    logic [25:0] scaled;

    // ************************************************************
    // Request detection and comparator
    // ************************************************************
    request_detect #(
        .REQ_CYCLES (REQ_CYCLES)
    ) u_req (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .scl_in       (scl_in),
        .scl_level    (scl_level),
        .request_seen (request_seen)
    );

    relay_compare u_cmp (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .update      (relay_upd),
        .obj_temp    (st_q.t.obj_first),
        .threshold   (st_q.thresh),
        .hysteresis  (st_q.hyst),
        .relay_level (relay_level)
    );

    // ************************************************************
    // Configuration decode
    // ************************************************************
    // Single shared filter lengths for every programmable stage
    assign pwm_en    = st_q.cfg[relay_pkg::PWM_EN_BIT];
    assign relay_sel = st_q.ctrl[relay_pkg::RELAY_SEL_BIT];
    assign dual_ir   = st_q.cfg[relay_pkg::DUAL_IR_BIT];
    assign fir_len   = st_q.cfg[relay_pkg::FIR_LSB +: 4];
    assign iir_len   = st_q.cfg[relay_pkg::IIR_LSB +: 4];
    assign relay_upd = st_q.lp == relay_pkg::ST_OBJ1 && st_q.tick == 8'h0;

    // Die result clamped to the linearization window
    assign die_clamped = (raw_die < relay_pkg::DIE_TEMP_LOW)  ? relay_pkg::DIE_TEMP_LOW :
                         (raw_die > relay_pkg::DIE_TEMP_HIGH) ? relay_pkg::DIE_TEMP_HIGH :
                         raw_die;

    // Rescale object result to 10 bits across the full result range
    assign scaled = 26'(st_q.t.obj_first) * 26'(relay_pkg::PWM_FULL);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        st_d       = st_q;
        st_d.load  = 1'b0;
        st_d.sda_s = {st_q.sda_s[0], sda_in};

        // Cell writes from the serial protocol engine
        if (nv_wr) begin
            unique case (nv_addr)
                relay_pkg::PWM_CTRL_ADDR: st_d.ctrl   = nv_wdata;
                relay_pkg::CFG_ADDR:      st_d.cfg    = nv_wdata;
                relay_pkg::HYST_ADDR:     st_d.hyst   = nv_wdata;
                relay_pkg::THRESH_ADDR:   st_d.thresh = nv_wdata;
                default:                  st_d.ctrl   = st_q.ctrl;
            endcase
        end

        // RAM read port; results are kelvin at 0.02 K per bit
        if (ram_rd) begin
            unique case (ram_addr)
                relay_pkg::DIE_TEMP_ADDR: st_d.rdata = st_q.t.die_temp;
                relay_pkg::OBJ1_ADDR:     st_d.rdata = st_q.t.obj_first;
                relay_pkg::OBJ2_ADDR:     st_d.rdata = st_q.t.obj_second;
                relay_pkg::PWM_CTRL_ADDR: st_d.rdata = st_q.ctrl;
                relay_pkg::CFG_ADDR:      st_d.rdata = st_q.cfg;
                relay_pkg::HYST_ADDR:     st_d.rdata = st_q.hyst;
                relay_pkg::THRESH_ADDR:   st_d.rdata = st_q.thresh;
                default:                  st_d.rdata = 16'h0;
            endcase
        end

        // Processing loop; runs in every output mode
        st_d.tick = (st_q.tick == 8'h0) ? 8'h0 : st_q.tick - 8'h1;
        if (st_q.tick == 8'h0) begin
            unique case (st_q.lp)
                relay_pkg::ST_LOAD: begin
                    st_d.lp   = relay_pkg::ST_AMB;
                    st_d.tick = 8'({4'h0, fir_len});
                end
                relay_pkg::ST_AMB: begin
                    st_d.t.die_temp = die_clamped;
                    st_d.lp         = relay_pkg::ST_OBJ1;
                    st_d.tick       = 8'({4'h0, iir_len});
                end
                relay_pkg::ST_OBJ1: begin
                    st_d.t.obj_first = raw_obj1;
                    st_d.lp = dual_ir ? relay_pkg::ST_OBJ2 : relay_pkg::ST_PWM;
                    st_d.tick = 8'({4'h0, fir_len});
                end
                relay_pkg::ST_OBJ2: begin
                    st_d.t.obj_second = raw_obj2;
                    st_d.lp           = relay_pkg::ST_PWM;
                    st_d.tick         = 8'({4'h0, iir_len});
                end
                relay_pkg::ST_PWM: begin
                    st_d.pwm  = scaled[25:16];
                    st_d.load = 1'b1;
                    st_d.lp   = relay_pkg::ST_AMB;
                    st_d.tick = 8'(relay_pkg::STAGE_CYCLES);
                end
                default: st_d.lp = relay_pkg::ST_AMB;
            endcase
        end

        // Output mode selection
        unique case (st_q.mode)
            relay_pkg::MODE_INIT: begin
                if (st_q.lp != relay_pkg::ST_LOAD) begin
                    if (!pwm_en) begin
                        st_d.mode = relay_pkg::MODE_SERIAL;
                    end else if (relay_sel) begin
                        st_d.mode = relay_pkg::MODE_RELAY;
                    end else begin
                        st_d.mode = relay_pkg::MODE_PWM;
                    end
                end
            end
            relay_pkg::MODE_PWM,
            relay_pkg::MODE_RELAY: begin
                if (request_seen) begin
                    st_d.mode = relay_pkg::MODE_SERIAL;
                end
            end
            relay_pkg::MODE_SERIAL: begin
                st_d.mode = relay_pkg::MODE_SERIAL;
            end
            default: st_d.mode = relay_pkg::MODE_INIT;
        endcase

        // Pin drive per mode and drive type
        unique case (st_q.mode)
            relay_pkg::MODE_RELAY,
            relay_pkg::MODE_PWM: begin
                // Relay uses comparator; PWM waveform lives elsewhere
                st_d.pin.pin_out = (st_q.mode == relay_pkg::MODE_RELAY) ?
                                   relay_level : 1'b0;
                if (st_q.ctrl[relay_pkg::DRIVE_TYPE_BIT]) begin
                    st_d.pin.pin_oe_b = 1'b0;
                end else begin
                    st_d.pin.pin_oe_b = st_d.pin.pin_out;
                end
            end
            relay_pkg::MODE_SERIAL: begin
                st_d.pin.pin_out  = 1'b0;
                st_d.pin.pin_oe_b = !ser_drive_low;
            end
            default: begin
                st_d.pin.pin_out  = 1'b0;
                st_d.pin.pin_oe_b = 1'b1;
            end
        endcase

        // Hold in load while calibration copies, so cell writes land first
        if (st_q.mode == relay_pkg::MODE_INIT && st_q.lp == relay_pkg::ST_LOAD) begin
            st_d.iir_acc = st_q.iir_acc + 16'h1;
            if (st_q.iir_acc < 16'(INIT_CYCLES)) begin
                st_d.lp   = relay_pkg::ST_LOAD;
                st_d.tick = 8'h0;
            end
        end
    end

    // ************************************************************
    // State register; reset is power-on or sleep exit
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q        <= '0;
            st_q.mode   <= relay_pkg::MODE_INIT;
            st_q.lp     <= relay_pkg::ST_LOAD;
            st_q.ctrl   <= relay_pkg::CTRL_RESET;
            st_q.cfg    <= relay_pkg::CFG_RESET;
            st_q.thresh <= relay_pkg::THRESH_RESET;
            st_q.hyst   <= relay_pkg::HYST_RESET;
            st_q.t.die_temp <= relay_pkg::DIE_TEMP_LOW; // Valid before first result
            st_q.pin    <= '{pin_out: 1'b0, pin_oe_b: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sda_out   = st_q.pin.pin_out;
    assign sda_oe_b  = st_q.pin.pin_oe_b;
    assign ram_rdata = st_q.rdata;
    assign out_mode  = st_q.mode;
    assign pwm_word  = st_q.pwm;
    assign pwm_load  = st_q.load;
    assign sda_seen  = st_q.sda_s[1];

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_request;
        request_seen && (st_q.mode == relay_pkg::MODE_PWM ||
                         st_q.mode == relay_pkg::MODE_RELAY);
    endsequence

    property p_request_to_serial;
        @(posedge ref_clk) disable iff (!rst_b)
        s_request |=> out_mode == relay_pkg::MODE_SERIAL;
    endproperty
    a_request_to_serial: assert property (p_request_to_serial)
        else $error("request did not enter serial mode");

    property p_serial_sticky;
        @(posedge ref_clk) disable iff (!rst_b)
        out_mode == relay_pkg::MODE_SERIAL |=> out_mode == relay_pkg::MODE_SERIAL;
    endproperty
    a_serial_sticky: assert property (p_serial_sticky)
        else $error("serial mode left without reset");

    property p_relay_cond;
        @(posedge ref_clk) disable iff (!rst_b)
        out_mode == relay_pkg::MODE_RELAY |-> pwm_en && relay_sel;
    endproperty
    a_relay_cond: assert property (p_relay_cond)
        else $error("relay mode without its enables");

    property p_die_range;
        @(posedge ref_clk) disable iff (!rst_b)
        st_q.lp != relay_pkg::ST_LOAD |-> st_q.t.die_temp >= relay_pkg::DIE_TEMP_LOW
            && st_q.t.die_temp <= relay_pkg::DIE_TEMP_HIGH;
    endproperty
    a_die_range: assert property (p_die_range)
        else $error("die temperature out of range");

    property p_skip_second;
        @(posedge ref_clk) disable iff (!rst_b)
        (st_q.lp == relay_pkg::ST_OBJ1 && st_q.tick == 8'h0 && !dual_ir)
            |=> st_q.lp == relay_pkg::ST_PWM;
    endproperty
    a_skip_second: assert property (p_skip_second)
        else $error("second object stage not skipped");

    property p_pwm_load;
        @(posedge ref_clk) disable iff (!rst_b)
        (st_q.lp == relay_pkg::ST_PWM && st_q.tick == 8'h0) |=> pwm_load;
    endproperty
    a_pwm_load: assert property (p_pwm_load)
        else $error("pwm word not loaded");

    property p_relay_pin;
        @(posedge ref_clk) disable iff (!rst_b)
        out_mode == relay_pkg::MODE_RELAY |=> sda_out == $past(relay_level);
    endproperty
    a_relay_pin: assert property (p_relay_pin)
        else $error("relay pin not following comparator");

    property p_pushpull;
        @(posedge ref_clk) disable iff (!rst_b)
        (out_mode == relay_pkg::MODE_RELAY && st_q.ctrl[relay_pkg::DRIVE_TYPE_BIT])
            |=> !sda_oe_b;
    endproperty
    a_pushpull: assert property (p_pushpull)
        else $error("push-pull drive not enabled");

    property p_nopwm_serial;
        @(posedge ref_clk) disable iff (!rst_b)
        (out_mode == relay_pkg::MODE_INIT && st_q.lp != relay_pkg::ST_LOAD && !pwm_en)
            |=> out_mode == relay_pkg::MODE_SERIAL;
    endproperty
    a_nopwm_serial: assert property (p_nopwm_serial)
        else $error("pwm disabled but serial not selected");
endmodule : out_mode_relay
`default_nettype wire

// >>> tb/scl_host.sv
// Host model driving the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module scl_host (
    // Pin levels toward the device
    output logic scl_in,
    output logic sda_in
);
    // ************************************************************
    // Idle: clock held high so the pulse output keeps running
    // ************************************************************
    initial begin
        scl_in = 1'b1;
        sda_in = 1'b1;
    end
    // Long low on the clock; data wiggles to show it is not looked at
    task automatic send_request(input int ns_low);
        scl_in = 1'b0;
        repeat (ns_low / 10) begin
            #10 sda_in = ~sda_in;
        end
        scl_in = 1'b1;
        // Short frame at the 80 ns link rate, then clock stands high
        repeat (4) begin
            #40 scl_in = 1'b0;
            #40 scl_in = 1'b1;
        end
        sda_in = 1'b1;
    endtask : send_request
endmodule : scl_host
`default_nettype wire

// >>> tb/out_mode_relay_tb_top.sv
// Self-checking bench for the output-mode and relay block
`timescale 1ns/1ps
`default_nettype none
module out_mode_relay_tb_top;
    // ************************************************************
    // Stimulus, observed pins and counters
    // ************************************************************
    logic        ref_clk = 1'b0, rst_b = 1'b0, ser_drive_low = 1'b0, nv_wr = 1'b0, ram_rd = 1'b0;
    logic [7:0]  nv_addr = 8'h00, ram_addr = 8'h00;
    logic [15:0] nv_wdata = 16'h0000, raw_die = 16'h3000, raw_obj1 = 16'h3000;
    logic [15:0] raw_obj2 = 16'h3000, o;
    logic [15:0] tbl [4] = '{16'h3686, 16'h3623, 16'h3622, 16'h3685};
    wire logic   scl_in, sda_in, sda_out, sda_oe_b, pwm_load, sda_seen;
    wire logic [15:0] ram_rdata;
    wire logic [1:0]  out_mode;
    wire logic [9:0]  pwm_word;
    int          err_total = 0, num_checks = 0, lvl = 0, v, i;

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    scl_host i_host (.scl_in(scl_in), .sda_in(sda_in));
    out_mode_relay #(.REQ_CYCLES(50), .INIT_CYCLES(16)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_b(sda_oe_b), .ser_drive_low(ser_drive_low),
        .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .ram_rd(ram_rd),
        .ram_addr(ram_addr), .ram_rdata(ram_rdata), .raw_die(raw_die),
        .raw_obj1(raw_obj1), .raw_obj2(raw_obj2), .out_mode(out_mode),
        .pwm_word(pwm_word), .pwm_load(pwm_load), .sda_seen(sda_seen));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic step();
        @(posedge ref_clk) #1;
    endtask : step
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic nv(input logic [7:0] a, input logic [15:0] d);
        step();
        nv_wr = 1'b1;
        nv_addr = a;
        nv_wdata = d;
        step();
        nv_wr = 1'b0;
    endtask : nv
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        step();
        ram_rd = 1'b1;
        ram_addr = a;
        step();
        ram_rd = 1'b0;
        chk(n, e, ram_rdata);
    endtask : rd
    // Reset counts as power-on or sleep exit; cells are rewritten after it
    task automatic boot(input logic [15:0] cfg, input logic [15:0] ctrl);
        step();
        rst_b = 1'b0;
        repeat (4) step();
        rst_b = 1'b1;
        nv(relay_pkg::CFG_ADDR, cfg);
        nv(relay_pkg::PWM_CTRL_ADDR, ctrl);
        nv(relay_pkg::THRESH_ADDR, 16'h6ca8);
        nv(relay_pkg::HYST_ADDR, 16'h0064);
        repeat (40) step();
    endtask : boot
    // Reference comparator: result is 0.02 K, switching points 0.01 K
    task automatic settle(input logic [15:0] t);
        raw_obj1 = t;
        if (2 * int'(t) >= 27816 + 100) lvl = 1;
        else if (2 * int'(t) <= 27816 - 100) lvl = 0;
        repeat (60) step();
    endtask : settle
    task automatic complete_run();
        if (err_total == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected run of roughly eleven hundred cycles
    initial begin
        #300000;
        err_total++;
        complete_run();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h8c70b545));
        boot(16'h0042, 16'h000c);
        chk("mode", 16'(relay_pkg::MODE_RELAY), 16'(out_mode));
        chk("sda_seen", 16'h1, 16'(sda_seen));
        for (v = 0; v < 8; v++) begin
            o = (v < 4) ? tbl[v] : 16'h3600 + 16'($urandom % 160);
            raw_obj2 = 16'($urandom);
            raw_die = 16'h2de4 + 16'($urandom % 8160);
            settle(o);
            chk("pin", 16'(lvl), 16'(sda_out));
            chk("oe_b", 16'h0, 16'(sda_oe_b));
            rd(relay_pkg::DIE_TEMP_ADDR, raw_die, "die");
            rd(relay_pkg::OBJ1_ADDR, o, "obj1");
            rd(relay_pkg::OBJ2_ADDR, raw_obj2, "obj2");
            for (i = 0; i < 100 && pwm_load !== 1'b1; i++) step();
            chk("load", 16'h1, 16'(pwm_load));
            chk("pwm", 16'((int'(o) * 1023) >> 16), 16'(pwm_word));
        end
        // Open drain: released for high, pulled for low
        nv(relay_pkg::PWM_CTRL_ADDR, 16'h0008);
        settle(16'h3686);
        chk("oe_b", 16'h1, 16'(sda_oe_b));
        settle(16'h3622);
        chk("oe_b", 16'h0, 16'(sda_oe_b));
        chk("pin", 16'h0, 16'(sda_out));
        i_host.send_request(1000);
        repeat (10) step();
        chk("mode", 16'(relay_pkg::MODE_SERIAL), 16'(out_mode));
        ser_drive_low = 1'b1;
        repeat (4) step();
        chk("oe_b", 16'h0, 16'(sda_oe_b));
        ser_drive_low = 1'b0;
        raw_die = 16'h3a00;
        settle(16'h3686);
        rd(relay_pkg::DIE_TEMP_ADDR, 16'h3a00, "die");
        chk("mode", 16'(relay_pkg::MODE_SERIAL), 16'(out_mode));
        boot(16'h0002, 16'h0004);
        chk("mode", 16'(relay_pkg::MODE_PWM), 16'(out_mode));
        rd(relay_pkg::OBJ2_ADDR, 16'h0000, "obj2");
        boot(16'h0000, 16'h0004);
        chk("mode", 16'(relay_pkg::MODE_SERIAL), 16'(out_mode));
        complete_run();
    end
endmodule : out_mode_relay_tb_top
`default_nettype wire
